//--- bfg_pkg.sv
// Constants, encodings and register map of the breaker failure guard
//
// Contract
// - After a trip, a trigger that persists means the breaker stayed closed: failure.
// - A retrip output reissues the trip to a breaker that failed to open.
// - If retrip does not clear it, the breaker failure output trips upstream.
// - A retrip enable setting; when off no retrip output is ever produced.
// - Start by current, output relay command, binary signal, or any combination; the code offers each pair and all three ANDed, and only all three ORed.
// - Current mode compares all three phases and the chosen residual continuously.
// - Signal mode lets any selected internal binary signal trigger the function.
// - Output mode watches the selected output relay control commands.
// - Comparisons use fundamental frequency magnitudes only.
// - Residual source: first input, second input, or derived from phases.
// - Watched lists, node mode and forcing are static, not setting-group dependent.
// - Signal list starts the countdown only when the mode includes signals.
// - Relay list starts the countdown only when the mode includes relays.
// - Node mode On, Blocked, Test, Test/Blocked, Off; default On; needs individual mode allowed.
// - Forcing drives state Normal, Start, Retrip, Failure, Blocked; needs forcing enabled.
// - A current pickup releases only below 97 percent of its threshold.
// - Block sampled at cycle start; active at pickup means blocked, no timing.
package bfg_pkg;

    localparam int unsigned ADDR_W = 6;

    localparam logic [5:0] OFF_CTRL      = 6'h00;
    localparam logic [5:0] OFF_PHASE_SET = 6'h04;
    localparam logic [5:0] OFF_RES_SET   = 6'h08;
    localparam logic [5:0] OFF_SIG_SEL   = 6'h0c;
    localparam logic [5:0] OFF_RELAY_SEL = 6'h10;
    localparam logic [5:0] OFF_RETR_TIME = 6'h14;
    localparam logic [5:0] OFF_FAIL_TIME = 6'h18;
    localparam logic [5:0] OFF_STATUS    = 6'h1c;
    localparam logic [5:0] OFF_IRQ_STAT  = 6'h20;
    localparam logic [5:0] OFF_IRQ_MASK  = 6'h24;

    // Control register fields
    localparam int unsigned CTRL_MODE_LSB  = 0;
    localparam int unsigned CTRL_RETR_BIT  = 3;
    localparam int unsigned CTRL_FORCE_LSB = 4;
    localparam int unsigned CTRL_FORCE_EN  = 7;
    localparam int unsigned CTRL_INDIV_BIT = 8;
    localparam int unsigned CTRL_RES_LSB   = 9;
    localparam int unsigned CTRL_ACT_LSB   = 12;

    localparam logic [31:0] CTRL_RESET      = 32'h0000_0008;
    localparam logic [15:0] PHASE_SET_RESET = 16'h0014;
    localparam logic [15:0] RES_SET_RESET   = 16'h0078;
    localparam logic [15:0] RETR_TIME_RESET = 16'h000a;
    localparam logic [15:0] FAIL_TIME_RESET = 16'h0014;

    // Release at 97 percent of pickup threshold
    localparam logic [6:0] REL_NUM = 7'h61;
    localparam logic [6:0] REL_DEN = 7'h64;

    // Program cycle of 5 ms at 20 MHz
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned PROG_CYCLE_US = 5000;
    localparam int unsigned PROG_CYCLES   = CLK_HZ / 1_000_000 * PROG_CYCLE_US;

    localparam int unsigned IRQ_START = 0;
    localparam int unsigned IRQ_RETR  = 1;
    localparam int unsigned IRQ_FAIL  = 2;
    localparam int unsigned IRQ_BLK   = 3;

    typedef enum logic [2:0] {
        NM_ON      = 3'b000,
        NM_BLOCKED = 3'b001,
        NM_TEST    = 3'b010,
        NM_TESTBLK = 3'b011,
        NM_OFF     = 3'b100
    } bfg_node_e;

    typedef enum logic [2:0] {
        ST_NORMAL  = 3'b000,
        ST_START   = 3'b001,
        ST_RETRIP  = 3'b010,
        ST_FAILURE = 3'b011,
        ST_BLOCKED = 3'b100
    } bfg_state_e;

    typedef enum logic [1:0] {
        RS_NONE    = 2'b00,
        RS_ONE     = 2'b01,
        RS_TWO     = 2'b10,
        RS_DERIVED = 2'b11
    } bfg_res_e;

    typedef enum logic [2:0] {
        AM_CUR         = 3'b000,
        AM_DO          = 3'b001,
        AM_SIG         = 3'b010,
        AM_CUR_AND_DO  = 3'b011,
        AM_CUR_AND_SIG = 3'b100,
        AM_SIG_AND_DO  = 3'b101,
        AM_ALL_AND     = 3'b110,
        AM_ANY_OR      = 3'b111
    } bfg_act_e;

endpackage : bfg_pkg

//--- bfg_top.sv
// Breaker failure guard with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none

module bfg_top #(
    parameter int unsigned PROG_CYCLES = bfg_pkg::PROG_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic [15:0] IL1_MAG,
    input  wire logic [15:0] IL2_MAG,
    input  wire logic [15:0] IL3_MAG,
    input  wire logic [15:0] RES_ONE_MAG,
    input  wire logic [15:0] RES_TWO_MAG,
    input  wire logic [15:0] RES_DERIVED_MAG,
    input  wire logic [15:0] SIG_IN,
    input  wire logic [15:0] RELAY_CMD,
    input  wire logic        BLOCK_IN,
    output logic             START_OUT,
    output logic             RETRIP_OUT,
    output logic             FAIL_OUT,
    output logic             BLOCKED_OUT,
    output logic             IRQ,
    input  wire logic [5:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [5:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);

    // Registers
    logic [31:0] ctrl_q;
    logic [15:0] phase_set_q;
    logic [15:0] res_set_q;
    logic [15:0] sig_sel_q;
    logic [15:0] relay_sel_q;
    logic [15:0] retr_time_q;
    logic [15:0] fail_time_q;
    logic [3:0]  irq_stat_q;
    logic [3:0]  irq_mask_q;

    // AXI write and read side
    logic        aw_have_q;
    logic [5:0]  aw_addr_q;
    logic        w_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;

    wire aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_fire  = S_AXI_WVALID && S_AXI_WREADY;
    wire ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
    assign S_AXI_WREADY  = !w_have_q && !bvalid_q;
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RRESP   = rresp_q;
    assign S_AXI_RDATA   = rdata_q;

    // Either channel may arrive first; the write lands once both are held
    wire        wr_go   = aw_have_q && w_have_q;
    wire [31:0] wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire        wr_ctrl = wr_go && aw_addr_q == bfg_pkg::OFF_CTRL;
    wire        wr_ps   = wr_go && aw_addr_q == bfg_pkg::OFF_PHASE_SET;
    wire        wr_rs   = wr_go && aw_addr_q == bfg_pkg::OFF_RES_SET;
    wire        wr_ss   = wr_go && aw_addr_q == bfg_pkg::OFF_SIG_SEL;
    wire        wr_rl   = wr_go && aw_addr_q == bfg_pkg::OFF_RELAY_SEL;
    wire        wr_rt   = wr_go && aw_addr_q == bfg_pkg::OFF_RETR_TIME;
    wire        wr_ft   = wr_go && aw_addr_q == bfg_pkg::OFF_FAIL_TIME;
    wire        wr_is   = wr_go && aw_addr_q == bfg_pkg::OFF_IRQ_STAT;
    wire        wr_im   = wr_go && aw_addr_q == bfg_pkg::OFF_IRQ_MASK;
    wire        wr_ok   = wr_ctrl || wr_ps || wr_rs || wr_ss || wr_rl || wr_rt || wr_ft || wr_is || wr_im
                          || (wr_go && aw_addr_q == bfg_pkg::OFF_STATUS);
    wire [31:0] wr_val  = w_data_q & wmask;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 6'h00;
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
        end
        else
        begin
            if (aw_fire)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {S_AXI_AWADDR[5:2], 2'h0};
            end
            if (w_fire)
            begin
                w_have_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
            if (wr_go)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? 2'h0 : 2'h2;
            end
            else if (bvalid_q && S_AXI_BREADY)
                bvalid_q <= 1'b0;
        end
    end

    // Settings are held apart from any setting group, so nothing else rewrites them
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ctrl_q      <= bfg_pkg::CTRL_RESET;
            phase_set_q <= bfg_pkg::PHASE_SET_RESET;
            res_set_q   <= bfg_pkg::RES_SET_RESET;
            sig_sel_q   <= 16'h0000;
            relay_sel_q <= 16'h0000;
            retr_time_q <= bfg_pkg::RETR_TIME_RESET;
            fail_time_q <= bfg_pkg::FAIL_TIME_RESET;
            irq_mask_q  <= 4'h0;
        end
        else
        begin
            if (wr_ctrl) ctrl_q <= (ctrl_q & ~wmask) | (wr_val & 32'h0000_7fff);
            if (wr_ps)   phase_set_q <= (phase_set_q & ~wmask[15:0]) | wr_val[15:0];
            if (wr_rs)   res_set_q   <= (res_set_q & ~wmask[15:0]) | wr_val[15:0];
            if (wr_ss)   sig_sel_q   <= (sig_sel_q & ~wmask[15:0]) | wr_val[15:0];
            if (wr_rl)   relay_sel_q <= (relay_sel_q & ~wmask[15:0]) | wr_val[15:0];
            if (wr_rt)   retr_time_q <= (retr_time_q & ~wmask[15:0]) | wr_val[15:0];
            if (wr_ft)   fail_time_q <= (fail_time_q & ~wmask[15:0]) | wr_val[15:0];
            if (wr_im)   irq_mask_q  <= (irq_mask_q & ~wmask[3:0]) | wr_val[3:0];
        end
    end

    // Settings decode
    wire        indiv_ok  = ctrl_q[bfg_pkg::CTRL_INDIV_BIT];
    wire [2:0]  mode_raw  = ctrl_q[bfg_pkg::CTRL_MODE_LSB +: 3];
    // Node mode only counts when individual setting is allowed, otherwise On
    wire [2:0]  node_mode = indiv_ok ? mode_raw : bfg_pkg::NM_ON;
    wire        retr_en   = ctrl_q[bfg_pkg::CTRL_RETR_BIT];
    wire        force_en  = ctrl_q[bfg_pkg::CTRL_FORCE_EN];
    wire [2:0]  force_st  = ctrl_q[bfg_pkg::CTRL_FORCE_LSB +: 3];
    wire [1:0]  res_sel   = ctrl_q[bfg_pkg::CTRL_RES_LSB +: 2];
    wire [2:0]  act_mode  = ctrl_q[bfg_pkg::CTRL_ACT_LSB +: 3];
    wire        mode_off  = node_mode == bfg_pkg::NM_OFF;
    wire        mode_blk  = node_mode == bfg_pkg::NM_BLOCKED || node_mode == bfg_pkg::NM_TESTBLK;
    // Test modes run the function but keep the trip contacts quiet
    wire        mode_test = node_mode == bfg_pkg::NM_TEST || node_mode == bfg_pkg::NM_TESTBLK;

    // Pin inputs: three flops, a change counts once stages two and three agree
    logic [32:0] pin_s1_q;
    logic [32:0] pin_s2_q;
    logic [32:0] pin_s3_q;
    logic [32:0] pin_q;
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pin_s1_q <= 33'h0;
            pin_s2_q <= 33'h0;
            pin_s3_q <= 33'h0;
            pin_q    <= 33'h0;
        end
        else
        begin
            pin_s1_q <= {BLOCK_IN, RELAY_CMD, SIG_IN};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
        end
    end
    wire [15:0] sig_v   = pin_q[15:0];
    wire [15:0] relay_v = pin_q[31:16];
    wire        blk_pin = pin_q[32];

    // Current pickup, four channels: three phases and residual
    logic [15:0] res_mag;
    always_comb
    begin
        case (res_sel)
            bfg_pkg::RS_ONE:     res_mag = RES_ONE_MAG;
            bfg_pkg::RS_TWO:     res_mag = RES_TWO_MAG;
            bfg_pkg::RS_DERIVED: res_mag = RES_DERIVED_MAG;
            default:             res_mag = 16'h0000;
        endcase
    end
    // Magnitudes arrive as fundamental frequency values only
    wire [63:0] mags = {res_mag, IL3_MAG, IL2_MAG, IL1_MAG};
    logic [3:0] pick_q;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pick
            wire [15:0] thr     = (gi == 3) ? res_set_q : phase_set_q;
            wire        used    = (gi != 3) || (res_sel != bfg_pkg::RS_NONE);
            wire [22:0] m_scale = 23'(mags[gi*16 +: 16]) * 23'(bfg_pkg::REL_DEN);
            wire [22:0] t_scale = 23'(thr) * 23'(bfg_pkg::REL_NUM);
            always_ff @(posedge CLK or negedge NRST)
            begin
                if (!NRST)
                    pick_q[gi] <= 1'b0;
                else if (!used)
                    pick_q[gi] <= 1'b0;
                else if (mags[gi*16 +: 16] > thr)
                    pick_q[gi] <= 1'b1;
                else if (m_scale < t_scale)
                    pick_q[gi] <= 1'b0;
            end
        end
    endgenerate

    // Trigger combination
    wire cur_trig = |pick_q;
    wire sig_trig = |(sig_v & sig_sel_q);
    wire do_trig  = |(relay_v & relay_sel_q);
    logic trig;
    always_comb
    begin
        case (act_mode)
            bfg_pkg::AM_CUR:         trig = cur_trig;
            bfg_pkg::AM_DO:          trig = do_trig;
            bfg_pkg::AM_SIG:         trig = sig_trig;
            bfg_pkg::AM_CUR_AND_DO:  trig = cur_trig && do_trig;
            bfg_pkg::AM_CUR_AND_SIG: trig = cur_trig && sig_trig;
            bfg_pkg::AM_SIG_AND_DO:  trig = sig_trig && do_trig;
            bfg_pkg::AM_ALL_AND:     trig = cur_trig && sig_trig && do_trig;
            bfg_pkg::AM_ANY_OR:      trig = cur_trig || sig_trig || do_trig;
            default:                 trig = 1'b0;
        endcase
    end

    // Program cycle tick; block and trigger are sampled only on it
    logic [31:0] pc_cnt_q;
    wire         tick = pc_cnt_q == PROG_CYCLES - 1;
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            pc_cnt_q <= 32'h0;
        else
            pc_cnt_q <= tick ? 32'h0 : pc_cnt_q + 32'h1;
    end
    wire blk_now = blk_pin || mode_blk;

    // Supervision state machine, timed in program cycles
    bfg_pkg::bfg_state_e st_q;
    bfg_pkg::bfg_state_e st_d;
    logic [15:0] tmr_q;
    wire         retr_due = retr_en && tmr_q >= retr_time_q;
    wire         fail_due = tmr_q >= fail_time_q;
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            bfg_pkg::ST_NORMAL:
                if (trig)
                    st_d = blk_now ? bfg_pkg::ST_BLOCKED : bfg_pkg::ST_START;
            bfg_pkg::ST_START, bfg_pkg::ST_RETRIP:
                if (!trig)
                    st_d = bfg_pkg::ST_NORMAL;
                else if (blk_now)
                    st_d = bfg_pkg::ST_BLOCKED;
                else if (fail_due)
                    st_d = bfg_pkg::ST_FAILURE;
                else if (retr_due)
                    st_d = bfg_pkg::ST_RETRIP;
            bfg_pkg::ST_FAILURE:
                if (!trig)
                    st_d = bfg_pkg::ST_NORMAL;
                else if (blk_now)
                    st_d = bfg_pkg::ST_BLOCKED;
            bfg_pkg::ST_BLOCKED:
                if (!trig)
                    st_d = bfg_pkg::ST_NORMAL;
            default:
                st_d = bfg_pkg::ST_NORMAL;
        endcase
        if (mode_off)
            st_d = bfg_pkg::ST_NORMAL;
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_q  <= bfg_pkg::ST_NORMAL;
            tmr_q <= 16'h0000;
        end
        else if (tick)
        begin
            st_q <= st_d;
            if (st_d == bfg_pkg::ST_START || st_d == bfg_pkg::ST_RETRIP || st_d == bfg_pkg::ST_FAILURE)
                tmr_q <= (tmr_q == 16'hffff) ? tmr_q : tmr_q + 16'h0001;
            else
                tmr_q <= 16'h0000;
        end
    end

    // Shown state: forcing overrides the supervised state
    wire [2:0] shown = force_en ? force_st : st_q;
    wire quiet  = mode_off || mode_test;
    wire ret_d  = !quiet && retr_en && (shown == bfg_pkg::ST_RETRIP || shown == bfg_pkg::ST_FAILURE);
    wire fail_d = !quiet && shown == bfg_pkg::ST_FAILURE;
    wire strt_d = shown == bfg_pkg::ST_START || shown == bfg_pkg::ST_RETRIP || shown == bfg_pkg::ST_FAILURE;
    wire blk_d  = shown == bfg_pkg::ST_BLOCKED;

    // Events on rising edges of the outputs; a set beats a same-cycle clear
    wire [3:0] ev_now = {blk_d, fail_d, ret_d, strt_d};
    logic [3:0] ev_q;
    wire  [3:0] ev_rise = ev_now & ~ev_q;
    wire  [3:0] is_clr  = wr_is ? wr_val[3:0] : 4'h0;
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ev_q        <= 4'h0;
            irq_stat_q  <= 4'h0;
            START_OUT   <= 1'b0;
            RETRIP_OUT  <= 1'b0;
            FAIL_OUT    <= 1'b0;
            BLOCKED_OUT <= 1'b0;
            IRQ         <= 1'b0;
        end
        else
        begin
            ev_q        <= ev_now;
            irq_stat_q  <= (irq_stat_q & ~is_clr) | ev_rise;
            START_OUT   <= strt_d;
            RETRIP_OUT  <= ret_d;
            FAIL_OUT    <= fail_d;
            BLOCKED_OUT <= blk_d;
            IRQ         <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read side
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        case ({S_AXI_ARADDR[5:2], 2'h0})
            bfg_pkg::OFF_CTRL:      rd_mux = ctrl_q;
            bfg_pkg::OFF_PHASE_SET: rd_mux = {16'h0, phase_set_q};
            bfg_pkg::OFF_RES_SET:   rd_mux = {16'h0, res_set_q};
            bfg_pkg::OFF_SIG_SEL:   rd_mux = {16'h0, sig_sel_q};
            bfg_pkg::OFF_RELAY_SEL: rd_mux = {16'h0, relay_sel_q};
            bfg_pkg::OFF_RETR_TIME: rd_mux = {16'h0, retr_time_q};
            bfg_pkg::OFF_FAIL_TIME: rd_mux = {16'h0, fail_time_q};
            bfg_pkg::OFF_STATUS:    rd_mux = {tmr_q, 5'h0, pick_q, ev_now, shown};
            bfg_pkg::OFF_IRQ_STAT:  rd_mux = {28'h0, irq_stat_q};
            bfg_pkg::OFF_IRQ_MASK:  rd_mux = {28'h0, irq_mask_q};
            default:
            begin
                rd_mux = 32'h0;
                rd_ok  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rvalid_q <= 1'b0;
            rresp_q  <= 2'h0;
            rdata_q  <= 32'h0;
        end
        else if (ar_fire)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_ok ? 2'h0 : 2'h2;
            rdata_q  <= rd_mux;
        end
        else if (rvalid_q && S_AXI_RREADY)
            rvalid_q <= 1'b0;
    end

    // Assertions
    sequence s_trig_free;
        tick && st_q == bfg_pkg::ST_NORMAL && trig && !blk_now && !mode_off;
    endsequence

    a_start_on_trig: assert property (@(posedge CLK) disable iff (!NRST)
        s_trig_free |=> st_q == bfg_pkg::ST_START)
        else $error("trigger did not start supervision");
    a_block_no_time: assert property (@(posedge CLK) disable iff (!NRST)
        tick && st_q == bfg_pkg::ST_NORMAL && trig && blk_now && !mode_off
        |=> st_q == bfg_pkg::ST_BLOCKED && tmr_q == 16'h0000)
        else $error("blocked pickup started timing");
    a_off_quiet: assert property (@(posedge CLK) disable iff (!NRST)
        mode_off |=> !RETRIP_OUT && !FAIL_OUT)
        else $error("output asserted in off mode");
    a_retrip_gate: assert property (@(posedge CLK) disable iff (!NRST)
        !retr_en |=> !RETRIP_OUT)
        else $error("retrip with retrip disabled");
    a_fail_follows: assert property (@(posedge CLK) disable iff (!NRST)
        tick && (st_q == bfg_pkg::ST_START || st_q == bfg_pkg::ST_RETRIP) && trig && !blk_now && fail_due && !mode_off
        |=> st_q == bfg_pkg::ST_FAILURE)
        else $error("failure not declared at fail time");
    a_retrip_due: assert property (@(posedge CLK) disable iff (!NRST)
        tick && st_q == bfg_pkg::ST_START && trig && !blk_now && retr_due && !fail_due && !mode_off
        |=> st_q == bfg_pkg::ST_RETRIP)
        else $error("retrip not entered");
    a_release_hyst: assert property (@(posedge CLK) disable iff (!NRST)
        pick_q[0] && IL1_MAG <= phase_set_q && 23'(IL1_MAG) * 23'd100 >= 23'(phase_set_q) * 23'd97
        |=> pick_q[0])
        else $error("phase pickup released above 97 percent");
    a_force_shows: assert property (@(posedge CLK) disable iff (!NRST)
        force_en && !quiet && force_st == bfg_pkg::ST_FAILURE |=> FAIL_OUT)
        else $error("forced failure not shown");
    a_clear_release: assert property (@(posedge CLK) disable iff (!NRST)
        tick && st_q != bfg_pkg::ST_NORMAL && !trig |=> st_q == bfg_pkg::ST_NORMAL)
        else $error("breaker open not recognised");

endmodule : bfg_top

`default_nettype wire

//--- bfg_breaker_model.sv
// Breaker and feeder model driving the line current
`timescale 1ns/100ps
`default_nettype none
module bfg_breaker_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [15:0] fault_level,
    input  wire logic        retrip_cmd,
    input  wire logic        fail_cmd,
    input  wire logic        coil_ok,
    output logic      [15:0] line_mag
);
    logic open_q;
    // A dead second coil ignores retrip; only the upstream trip then clears the line
    always_ff @(posedge clk or negedge nrst)
        if (!nrst) open_q <= 1'b0;
        else if (fault_level == 16'h0000) open_q <= 1'b0;
        else if ((retrip_cmd && coil_ok) || fail_cmd) open_q <= 1'b1;
    assign line_mag = open_q ? 16'h0000 : fault_level;
endmodule : bfg_breaker_model
`default_nettype wire

//--- bfg_top_tb.sv
// Self-checking bench for the breaker failure guard
`timescale 1ns/100ps
`default_nettype none
module bfg_top_tb;
    // Ready signals stay high: a response is always taken on the edge it is first seen
    logic        clk = 0, nrst = 0, blk = 0, ok = 0, awv = 0, wv = 0, bry = 1, arv = 0, rry = 1;
    logic [5:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0;
    logic [15:0] lvl = 0, sig = 0, rly = 0, res = 0;
    logic [3:0]  seen = 0;
    wire  logic  st, rt, fl, bk, irq, awr, wrdy, bv, arr, rv;
    wire  logic [1:0]  br, rr;
    wire  logic [15:0] mag;
    wire  logic [31:0] rdat;
    wire  logic [3:0]  outs = {st, rt, fl, bk};
    int          errors = 0, cmp_count = 0;
    bfg_top #(.PROG_CYCLES(4)) uut (.CLK(clk), .NRST(nrst), .IL1_MAG(mag), .IL2_MAG(mag), .IL3_MAG(mag),
        .RES_ONE_MAG(res), .RES_TWO_MAG(16'h0000), .RES_DERIVED_MAG(16'h0000), .SIG_IN(sig),
        .RELAY_CMD(rly), .BLOCK_IN(blk), .START_OUT(st), .RETRIP_OUT(rt), .FAIL_OUT(fl),
        .BLOCKED_OUT(bk), .IRQ(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
    bfg_breaker_model partner (.clk(clk), .nrst(nrst), .fault_level(lvl), .retrip_cmd(rt),
        .fail_cmd(fl), .coil_ok(ok), .line_mag(mag));
    always #25 clk = ~clk;
    always @(negedge clk) seen = seen | outs;
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wr(input logic [5:0] a, input logic [31:0] d);
        awa <= a; wd <= d; awv <= 1; wv <= 1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrdy) wv <= 0;
        end while (bv !== 1'b1);
    endtask : wr
    task rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
        ara <= a; arv <= 1;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 0;
        end while (rv !== 1'b1);
        chk("rdata", rdat, e);
        chk("rresp", {30'h0, rr}, {30'h0, er});
    endtask : rd
    task expect_outs(input logic [3:0] e, input int n);
        for (int i = 0; i < n && outs !== e; i++) @(posedge clk);
        chk("outs", {28'h0, outs}, {28'h0, e});
    endtask : expect_outs
    task fault(input logic [15:0] l, input logic b, input logic c);
        lvl <= l; blk <= b; ok <= c; seen = 0;
    endtask : fault
    task summarize;
        $display("Errors %0d of %0d compares", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1;
        rd(6'h00, 32'h8, 2'h0);
        rd(6'h04, 32'h14, 2'h0);
        rd(6'h28, 32'h0, 2'h2);
        wr(6'h14, 2); wr(6'h18, 5); wr(6'h24, 4);
        fault(16'h30, 0, 0);
        expect_outs(4'b1000, 40);
        expect_outs(4'b1100, 40);
        expect_outs(4'b1110, 60);
        repeat (2) @(posedge clk);
        chk("irq", irq, 1);
        expect_outs(4'b0000, 40);
        fault(0, 0, 1); wr(6'h20, 4);
        // The level output follows the cleared status one clock later
        @(posedge clk);
        chk("irq", irq, 0);
        fault(16'h30, 0, 1);
        expect_outs(4'b1100, 80);
        expect_outs(4'b0000, 40);
        chk("fail", seen[1], 0);
        fault(0, 0, 1); wr(6'h00, 0); fault(16'h30, 0, 1);
        expect_outs(4'b1010, 80);
        chk("retrip", seen[2], 0);
        fault(0, 0, 1); wr(6'h00, 32'h104); fault(16'h30, 0, 0);
        repeat (60) @(posedge clk);
        chk("off", seen, 0);
        // Block goes through the pin filter before the pickup can reach a tick
        fault(0, 1, 0); wr(6'h00, 8); @(posedge clk); fault(16'h30, 1, 0);
        expect_outs(4'b0001, 40);
        chk("start", seen[3], 0);
        fault(0, 0, 0); wr(6'h0c, 1); wr(6'h00, 32'h2008); sig <= 16'h0002; seen = 0;
        repeat (40) @(posedge clk);
        chk("unselected", seen, 0);
        sig <= 16'h0001;
        expect_outs(4'b1000, 40);
        sig <= 0; wr(6'h00, 0); wr(6'h18, 32'hffff);
        expect_outs(4'b0000, 40);
        fault(21, 0, 0);
        expect_outs(4'b1000, 40);
        lvl <= 20;
        repeat (20) @(posedge clk);
        chk("hold", st, 1);
        lvl <= 19;
        expect_outs(4'b0000, 40);
        wr(6'h10, 2); wr(6'h00, 32'h1000); rly <= 16'h0001; sig <= 16'h0001; seen = 0;
        repeat (40) @(posedge clk);
        chk("relay_list", seen, 0);
        rly <= 16'h0002;
        expect_outs(4'b1000, 40);
        wr(6'h00, 32'h10b8);
        expect_outs(4'b1110, 20);
        wr(6'h00, 32'h11ba);
        expect_outs(4'b1000, 20);
        rly <= 0; wr(6'h00, 0);
        expect_outs(4'b0000, 40);
        res <= 16'h0079; seen = 0;
        repeat (20) @(posedge clk);
        chk("res_none", seen, 0);
        wr(6'h00, 32'h0200);
        expect_outs(4'b1000, 40);
        summarize();
    end
endmodule : bfg_top_tb
`default_nettype wire
